// File: rtl/usx_serial_core.sv
// Overview of operation
// - Buffer-empty flag high exactly while buffer empty
// - Buffer-empty interrupt requested while flag set
// - Data write loads buffer, clears empty flag
// - Complete flag set when frame out, buffer empty
// - Complete flag cleared by service or one-write
// - Complete interrupt requested when complete flag sets
// - Parity bit sent between data and stop
// - Transmit disable waits for shifter and buffer
// - Receive enable takes over the input pin
// - Synchronous mode clocks bits from transfer pin
// - Valid start begins frame; second stop ignored
// - First stop moves frame into receive buffer
// - Short characters read with upper bits zero
// - Ninth bit and errors stored per entry
// - Start, data LSB first, parity, stops; idle high
// - Even parity is XOR; odd inverts it
// - Shifter loads when idle or after stop
// - Receive-complete tracks buffer; disable flushes it
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "usx_defines.svh"
module usx_serial_core (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialInPin,
  input wire logic transferClockPin,
  output logic serialOutPin,
  output logic serialOutEnable,
  output logic serialInOverride,
  input wire logic globalIrqEnable,
  input wire logic txCompleteAck,
  output logic txBufferEmptyIrq,
  output logic txCompleteIrq,
  output logic rxCompleteIrq
);
  usx_pkg::usx_core_s st, next_;
  usx_pkg::usx_entry_s head, newEntry;
  logic [1:0] fifoCount;
  logic txTick, rxTick, rxRestart, push, pop;
  logic wrAcc, rdAcc, rdSetup, mapped, dataWr, rxc, udre, headOk, txLoad, txcSet;
  logic [3:0] nBits;
  logic [8:0] charMask;
  logic [7:0] statusVal, ctrlBVal, ctrlCVal;

  // Data bits per character from the size code
  function automatic logic [3:0] dataBits(input logic [2:0] code);
    dataBits = (code == `USX_SZ_NINE) ? 4'h9 : 4'h5 + {2'h0, code[1:0]};
  endfunction : dataBits

  // Bus decode; every access completes without wait states
  assign wrAcc = psel & penable & pwrite;
  assign rdAcc = psel & penable & ~pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;
  assign dataWr = wrAcc && (paddr == `USX_A_DATA);
  assign mapped = paddr inside {`USX_A_STATUS, `USX_A_CTRLB, `USX_A_CTRLC, `USX_A_DATA, `USX_A_BAUD};
  assign pready = 1'b1;
  assign prdata = st.rdData;
  // Error flag is left over from the last read setup, so writes must mask it
  assign pslverr = st.rdErr & psel & penable & ~pwrite;
  assign pop = rdAcc & st.rdPop;

  // Flags and pins
  assign nBits = dataBits({st.sz2, st.sz});
  assign charMask = ~(9'h1FF << nBits);
  assign rxc = fifoCount != 2'h0;
  assign headOk = rxc;
  assign udre = ~st.txBufFull;
  assign serialOutPin = st.txLine;
  assign serialOutEnable = st.txOn;
  assign serialInOverride = st.rxen;

  // Interrupt requests are levels gated by enables
  // buffer-empty request
  assign txBufferEmptyIrq = udre & st.udrie & globalIrqEnable;
  assign txCompleteIrq = st.txc & st.txcie & globalIrqEnable;
  assign rxCompleteIrq = rxc & st.rxcie & globalIrqEnable;

  usx_bit_clock u_clk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .syncMode(st.syncMode),
    .baudDiv(st.baud),
    .transferClockPin(transferClockPin),
    .rxRestart(rxRestart),
    .txTick(txTick),
    .rxTick(rxTick)
  );

  usx_rx_fifo u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .flush(~st.rxen),
    .push(push),
    .pushEntry(newEntry),
    .pop(pop),
    .head(head),
    .count(fifoCount)
  );

  // Readable register images; status of the head entry only when valid
  always_comb begin
    statusVal = 8'h00;
    statusVal[`USX_ST_RXC] = rxc;
    statusVal[`USX_ST_TXC] = st.txc;
    statusVal[`USX_ST_UDRE] = udre;
    statusVal[`USX_ST_FE] = headOk & head.fe;
    statusVal[`USX_ST_DOR] = headOk & head.dor;
    statusVal[`USX_ST_UPE] = headOk & head.upe;
    ctrlBVal = 8'h00;
    ctrlBVal[`USX_CB_RXCIE] = st.rxcie;
    ctrlBVal[`USX_CB_TXCIE] = st.txcie;
    ctrlBVal[`USX_CB_UDRIE] = st.udrie;
    ctrlBVal[`USX_CB_RXEN] = st.rxen;
    ctrlBVal[`USX_CB_TRANSMIT_ENABLE_BIT] = st.transmit_enable_bit;
    ctrlBVal[`USX_CB_SZ2] = st.sz2;
    ctrlBVal[`USX_CB_RXB8] = headOk & head.data[8];
    ctrlBVal[`USX_CB_TX_NINTH_BIT] = st.tx_ninth_bit;
    ctrlCVal = 8'h00;
    ctrlCVal[`USX_CC_SYNC] = st.syncMode;
    ctrlCVal[`USX_CC_UPM] = st.upm;
    ctrlCVal[`USX_CC_USBS] = st.usbs;
    ctrlCVal[`USX_CC_SZ] = st.sz;
  end

  // Frame leaving the shifter at the first stop bit
  assign newEntry = '{data: st.rxShift, fe: ~st.rxSync, dor: st.dorPending, upe: st.rxPerr & st.upm[1]};
  assign push = st.rxen && (st.rxState == usx_pkg::RX_STOP) && rxTick && (fifoCount != `USX_FIFO_FULL);
  assign rxRestart = st.rxen && !st.syncMode && (st.rxState == usx_pkg::RX_IDLE) && !st.rxSync;

  // Whole next state: bus, transmitter, receiver
  always_comb begin
    next_ = st;
    txLoad = 1'b0;
    txcSet = 1'b0;
    next_.rxMeta = serialInPin;
    next_.rxSync = st.rxMeta;
    // Read data are caught in the setup cycle; pop only what was shown
    if (rdSetup) begin
      next_.rdErr = !mapped;
      next_.rdPop = (paddr == `USX_A_DATA) && headOk;
      unique case (paddr)
        `USX_A_STATUS: next_.rdData = {24'h0, statusVal};
        `USX_A_CTRLB: next_.rdData = {24'h0, ctrlBVal};
        `USX_A_CTRLC: next_.rdData = {24'h0, ctrlCVal};
        `USX_A_DATA: next_.rdData = headOk ? {24'h0, head.data[7:0]} : 32'h0;
        `USX_A_BAUD: next_.rdData = {20'h0, st.baud};
        default: next_.rdData = 32'h0;
      endcase
    end
    if (wrAcc && (paddr == `USX_A_CTRLB)) begin
      next_.rxcie = pwdata[`USX_CB_RXCIE];
      next_.txcie = pwdata[`USX_CB_TXCIE];
      next_.udrie = pwdata[`USX_CB_UDRIE];
      next_.rxen = pwdata[`USX_CB_RXEN];
      next_.transmit_enable_bit = pwdata[`USX_CB_TRANSMIT_ENABLE_BIT];
      next_.sz2 = pwdata[`USX_CB_SZ2];
      next_.tx_ninth_bit = pwdata[`USX_CB_TX_NINTH_BIT];
    end
    if (wrAcc && (paddr == `USX_A_CTRLC)) begin
      next_.syncMode = pwdata[`USX_CC_SYNC];
      next_.upm = pwdata[`USX_CC_UPM];
      next_.usbs = pwdata[`USX_CC_USBS];
      next_.sz = pwdata[`USX_CC_SZ];
    end
    if (wrAcc && (paddr == `USX_A_BAUD)) begin
      next_.baud = pwdata[11:0];
    end
    // Transmit frame sequencer, stepped on the bit tick; TX_DATA spans all data bits
    unique case (st.txState)
      usx_pkg::TX_IDLE: txLoad = st.txOn && st.txBufFull;
      usx_pkg::TX_START: if (txTick) begin
        next_.txLine = 1'b0;
        next_.txState = usx_pkg::TX_DATA;
      end
      usx_pkg::TX_DATA: if (txTick) begin
        next_.txLine = st.txShift[st.txCnt];
        next_.txCnt = st.txCnt + 4'h1;
        if (st.txCnt == nBits - 4'h1) begin
          next_.txState = st.upm[1] ? usx_pkg::TX_PAR : usx_pkg::TX_STOP1;
        end
      end
      usx_pkg::TX_PAR: if (txTick) begin
        next_.txLine = st.txPar;
        next_.txState = usx_pkg::TX_STOP1;
      end
      usx_pkg::TX_STOP1: if (txTick) begin
        next_.txLine = 1'b1;
        next_.txState = st.usbs ? usx_pkg::TX_STOP2 : usx_pkg::TX_END;
      end
      usx_pkg::TX_STOP2: if (txTick) begin
        next_.txState = usx_pkg::TX_END;
      end
      // Last stop period is over: chain the next frame or finish
      usx_pkg::TX_END: if (txTick) begin
        if (st.txOn && st.txBufFull) begin
          txLoad = 1'b1;
        end else begin
          txcSet = 1'b1;
          next_.txState = usx_pkg::TX_IDLE;
        end
      end
      default: next_.txState = usx_pkg::TX_IDLE;
    endcase
    if (txLoad) begin
      next_.txShift = st.txBuf;
      next_.txPar = ^(st.txBuf & charMask) ^ st.upm[0];
      next_.txCnt = 4'h0;
      next_.txBufFull = 1'b0;
      next_.txState = (st.txState == usx_pkg::TX_END) ? usx_pkg::TX_DATA : usx_pkg::TX_START;
      if (st.txState == usx_pkg::TX_END) begin
        next_.txLine = 1'b0;
      end
    end
    // data write fills buffer, after a same-cycle load
    if (dataWr) begin
      next_.txBuf = {st.tx_ninth_bit, pwdata[7:0]};
      next_.txBufFull = 1'b1;
    end
    next_.txOn = st.transmit_enable_bit | (st.txOn & ((st.txState != usx_pkg::TX_IDLE) | st.txBufFull));
    // clear by service or one-write; set wins
    if (txCompleteAck || (wrAcc && (paddr == `USX_A_STATUS) && pwdata[`USX_ST_TXC])) begin
      next_.txc = 1'b0;
    end
    if (txcSet) begin
      next_.txc = 1'b1;
    end
    unique case (st.rxState)
      usx_pkg::RX_IDLE: if (rxRestart) begin
        next_.rxState = usx_pkg::RX_START;
      end else if (st.syncMode && rxTick && !st.rxSync) begin
        next_.rxState = usx_pkg::RX_DATA;
        next_.rxShift = 9'h000;
        next_.rxCnt = 4'h0;
      end
      // Mid-bit recheck rejects glitches as start bits
      usx_pkg::RX_START: if (rxTick) begin
        next_.rxState = st.rxSync ? usx_pkg::RX_IDLE : usx_pkg::RX_DATA;
        next_.rxShift = 9'h000;
        next_.rxCnt = 4'h0;
      end
      usx_pkg::RX_DATA: if (rxTick) begin
        next_.rxShift[st.rxCnt] = st.rxSync;
        next_.rxCnt = st.rxCnt + 4'h1;
        if (st.rxCnt == nBits - 4'h1) begin
          next_.rxState = st.upm[1] ? usx_pkg::RX_PAR : usx_pkg::RX_STOP;
        end
      end
      usx_pkg::RX_PAR: if (rxTick) begin
        next_.rxPerr = st.rxSync != (^(st.rxShift & charMask) ^ st.upm[0]);
        next_.rxState = usx_pkg::RX_STOP;
      end
      // Only the first stop is checked; a second one looks like idle
      usx_pkg::RX_STOP: if (rxTick) begin
        next_.rxState = usx_pkg::RX_IDLE;
        next_.rxPerr = 1'b0;
        next_.dorPending = !push;
      end
      default: next_.rxState = usx_pkg::RX_IDLE;
    endcase
    if (!st.rxen) begin
      next_.rxState = usx_pkg::RX_IDLE;
      next_.dorPending = 1'b0;
      next_.rxPerr = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.txLine <= 1'b1;
      st.rxMeta <= 1'b1;
      st.rxSync <= 1'b1;
      st.sz <= `USX_SZ_RST;
      st.baud <= `USX_BAUD_RST;
    end else begin
      st <= next_;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence txLoadS;
    st.txState == usx_pkg::TX_IDLE && st.txOn && st.txBufFull && !dataWr;
  endsequence
  sequence txStartS;
    st.txState == usx_pkg::TX_START && !st.txBufFull;
  endsequence

  data_write_a: assert property (dataWr |=> !udre) else $error("data write left buffer empty");
  empty_irq_a: assert property (txBufferEmptyIrq && !dataWr
    |=> txBufferEmptyIrq || !(st.udrie && globalIrqEnable)) else $error("buffer-empty request dropped");
  idle_load_a: assert property (txLoadS |=> txStartS) else $error("shifter did not load");
  tx_done_a: assert property (st.txState == usx_pkg::TX_END && txTick && !st.txBufFull |=> st.txc)
    else $error("complete flag not set");
  txc_clear_a: assert property (txCompleteAck && !txcSet |=> !st.txc)
    else $error("complete flag not cleared");
  txc_irq_a: assert property ($rose(st.txc) && st.txcie && globalIrqEnable |-> txCompleteIrq)
    else $error("complete request missing");
  parity_out_a: assert property (st.txState == usx_pkg::TX_PAR && txTick
    |=> serialOutPin == $past(st.txPar)) else $error("parity bit wrong");
  tx_release_a: assert property ($fell(serialOutEnable)
    |-> st.txState == usx_pkg::TX_IDLE && !$past(st.txBufFull)) else $error("transmitter released early");
  rx_push_a: assert property (push && !pop |=> fifoCount == $past(fifoCount) + 2'h1)
    else $error("frame not buffered");
  rx_flush_a: assert property (!st.rxen |=> !rxc) else $error("buffer not flushed");
endmodule : usx_serial_core
`default_nettype wire

// File: inc/usx_defines.svh
`ifndef USX_DEFINES_SVH
`define USX_DEFINES_SVH
// Register byte addresses
`define USX_A_STATUS 12'h000
`define USX_A_CTRLB 12'h004
`define USX_A_CTRLC 12'h008
`define USX_A_DATA 12'h00C
`define USX_A_BAUD 12'h010
// Status register bits
`define USX_ST_RXC 7
`define USX_ST_TXC 6
`define USX_ST_UDRE 5
`define USX_ST_FE 4
`define USX_ST_DOR 3
`define USX_ST_UPE 2
// Control register B bits
`define USX_CB_RXCIE 7
`define USX_CB_TXCIE 6
`define USX_CB_UDRIE 5
`define USX_CB_RXEN 4
`define USX_CB_TRANSMIT_ENABLE_BIT 3
`define USX_CB_SZ2 2
`define USX_CB_RXB8 1
`define USX_CB_TX_NINTH_BIT 0
// Control register C fields
`define USX_CC_SYNC 6
`define USX_CC_UPM 5:4
`define USX_CC_USBS 3
`define USX_CC_SZ 2:1
// Reset values and codes
`define USX_SZ_RST 2'h3
`define USX_BAUD_RST 12'h000
`define USX_SZ_NINE 3'h7
`define USX_FIFO_FULL 2'h2
`endif

// File: inc/usx_pkg.sv
package usx_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3,
    TX_STOP1 = 3'h4, TX_STOP2 = 3'h5, TX_END = 3'h6
  } usx_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3, RX_STOP = 3'h4
  } usx_rx_e;
  // One buffered frame with its status
  typedef struct packed {
    logic [8:0] data;
    logic fe, dor, upe;
  } usx_entry_s;
  typedef struct packed {
    usx_entry_s slot0, slot1;
    logic [1:0] count;
  } usx_fifo_s;
  typedef struct packed {
    logic xckMeta, xckSync, xckPrev, txTick, rxTick;
    logic [11:0] txCnt, rxCnt;
  } usx_clk_s;
  typedef struct packed {
    logic rxcie, txcie, udrie, rxen, transmit_enable_bit, sz2, tx_ninth_bit;
    logic syncMode, usbs;
    logic [1:0] upm, sz;
    logic [11:0] baud;
    logic txc, txBufFull, txOn, txLine, txPar;
    logic [8:0] txBuf, txShift;
    logic [3:0] txCnt;
    usx_tx_e txState;
    logic rxMeta, rxSync, rxPerr, dorPending;
    logic [8:0] rxShift;
    logic [3:0] rxCnt;
    usx_rx_e rxState;
    logic [31:0] rdData;
    logic rdErr, rdPop;
  } usx_core_s;
endpackage : usx_pkg

// File: rtl/usx_bit_clock.sv
`timescale 1ns/10ps
`default_nettype none
module usx_bit_clock (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic syncMode,
  input wire logic [11:0] baudDiv,
  input wire logic transferClockPin,
  input wire logic rxRestart,
  output logic txTick,
  output logic rxTick
);
  usx_pkg::usx_clk_s st, next_;
  logic xckRise;

  // Edge taken after the second stage only
  assign xckRise = st.xckSync & ~st.xckPrev;
  assign txTick = st.txTick;
  assign rxTick = st.rxTick;

  // Bit ticks: divider period baudDiv+1, or the outside transfer clock
  always_comb begin
    next_ = st;
    next_.xckMeta = transferClockPin;
    next_.xckSync = st.xckMeta;
    next_.xckPrev = st.xckSync;
    next_.txTick = 1'b0;
    next_.rxTick = 1'b0;
    if (syncMode) begin
      next_.txTick = xckRise;
      next_.rxTick = xckRise;
    end else begin
      if (st.txCnt == 12'h000) begin
        next_.txCnt = baudDiv;
        next_.txTick = 1'b1;
      end else begin
        next_.txCnt = st.txCnt - 12'h001;
      end
      // Restart lands the samples mid bit
      if (rxRestart) begin
        next_.rxCnt = {1'b0, baudDiv[11:1]};
      end else if (st.rxCnt == 12'h000) begin
        next_.rxCnt = baudDiv;
        next_.rxTick = 1'b1;
      end else begin
        next_.rxCnt = st.rxCnt - 12'h001;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_;
    end
  end
endmodule : usx_bit_clock
`default_nettype wire

// File: rtl/usx_rx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "usx_defines.svh"
module usx_rx_fifo (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic push,
  input wire usx_pkg::usx_entry_s pushEntry,
  input wire logic pop,
  output usx_pkg::usx_entry_s head,
  output logic [1:0] count
);
  usx_pkg::usx_fifo_s st, next_;
  logic popOk;
  logic pushOk;

  // Head always sits in slot0, so read data come from a register
  assign head = st.slot0;
  assign count = st.count;
  assign popOk = pop && (st.count != 2'h0);
  assign pushOk = push && ((st.count != `USX_FIFO_FULL) || popOk);

  // Shift-style two entry queue; flush wins over everything
  always_comb begin
    logic [1:0] cnt;
    cnt = st.count;
    next_ = st;
    if (popOk) begin
      next_.slot0 = st.slot1;
      cnt = cnt - 2'h1;
    end
    if (pushOk) begin
      if (cnt == 2'h0) begin
        next_.slot0 = pushEntry;
      end else begin
        next_.slot1 = pushEntry;
      end
      cnt = cnt + 2'h1;
    end
    next_.count = flush ? 2'h0 : cnt;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_;
    end
  end
endmodule : usx_rx_fifo
`default_nettype wire

// File: dv/usx_remote_node.sv
`timescale 1ns/10ps
`default_nettype none
module usx_remote_node #(
  parameter int P = 4
) (
  input wire logic core_clk,
  input wire logic serialOutPin,
  input wire logic serialOutEnable,
  output logic serialInPin,
  output logic transferClockPin
);
  // Data plus parity bits expected per frame, stop bit follows
  int nBits = 9;
  logic [9:0] got;
  logic [9:0] q[$];
  initial begin
    serialInPin = 1'h1;
    transferClockPin = 1'h0;
  end
  // start, LSB first, stop
  // Line is ignored while the pin is not driven, so a floating pin never looks like a start
  // Sampled on the falling edge, where the line launched at the rising edge has settled
  always begin
    @(negedge core_clk);
    if (serialOutEnable === 1'h1 && serialOutPin === 1'h0) begin
      repeat (P / 2) @(negedge core_clk);
      got = 10'h3FF;
      for (int i = 0; i <= nBits; i++) begin
        repeat (P) @(negedge core_clk);
        got[i] = serialOutPin;
      end
      q.push_back(got);
    end
  end
  // idle high after frame
  // Bit 0 is the start bit; trailing ones leave the line idle, so no release step is needed
  // Transfer clock rises one cycle into each bit and rests low between frames
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      serialInPin <= f[i];
      @(posedge core_clk);
      transferClockPin <= 1'h1;
      repeat (P / 2) @(posedge core_clk);
      transferClockPin <= 1'h0;
      repeat (P / 2 - 1) @(posedge core_clk);
    end
  endtask : send
endmodule : usx_remote_node
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "usx_defines.svh"
module tb;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, sIn, sOut, sOutEn, sInOvr, xck;
  logic gie = 1'h1;
  logic ack = 1'h0;
  logic udreIrq, txcIrq, rxcIrq;
  int failCount = 0;
  int numChecks = 0;
  int cyc = 0;
  // Remote node bit period equals BAUD+1 with BAUD set to 3 below
  usx_remote_node #(.P(4)) node (.core_clk(core_clk), .serialOutPin(sOut),
    .serialOutEnable(sOutEn), .serialInPin(sIn), .transferClockPin(xck));
  // The remote node clocks its own frames; only synchronous mode listens to that clock
  usx_serial_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialInPin(sIn), .transferClockPin(xck), .serialOutPin(sOut),
    .serialOutEnable(sOutEn), .serialInOverride(sInOvr), .globalIrqEnable(gie),
    .txCompleteAck(ack), .txBufferEmptyIrq(udreIrq), .txCompleteIrq(txcIrq),
    .rxCompleteIrq(rxcIrq));
  // Clock
  always #5 core_clk = ~core_clk;
  // Run needs under a thousand cycles; the ceiling leaves wide margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failCount++;
      endOfTest();
    end
  end
  task automatic endOfTest();
    if (failCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : endOfTest
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; an idle edge follows so strobes are never reassigned in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    for (k = 0; k < 50 && pready !== 1'h1; k++) @(posedge core_clk);
    chk("pready", 32'h1, {31'h0, pready});
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(n, e, rdat);
  endtask : rdc
  // Polls status until a bit of the mask is set, bounded
  task automatic waitSt(input logic [31:0] m);
    int k;
    for (k = 0; k < 100; k++) begin
      apb(1'h0, `USX_A_STATUS, 32'h0);
      if ((rdat & m) !== 32'h0) break;
    end
    chk("stWait", 32'h1, 32'(k < 100));
  endtask : waitSt
  // Waits for one frame at the remote node and compares stop, parity and data
  task automatic chkTx(input logic [9:0] e);
    int k;
    for (k = 0; k < 400 && node.q.size() == 0; k++) @(posedge core_clk);
    chk("txCount", 32'h1, 32'(node.q.size() != 0));
    if (node.q.size() != 0) chk("txFrame", {22'h0, e}, {22'h0, node.q.pop_front()});
  endtask : chkTx
  // Builds a line frame: start, data LSB first, optional parity, stop, then idle ones
  function automatic logic [11:0] fr(input logic [8:0] d, input int n, input logic pe,
    input logic odd, input logic stp);
    logic [11:0] f;
    logic p;
    int k;
    f = 12'hFFF;
    f[0] = 1'h0;
    p = odd;
    for (k = 0; k < n; k++) begin
      f[k + 1] = d[k];
      p = p ^ d[k];
    end
    if (pe) begin
      f[k + 1] = p;
      k++;
    end
    f[k + 1] = stp;
    return f;
  endfunction : fr
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    chk("txLine", 32'h1, sOut);
    chk("txOe", 32'h0, sOutEn);
    rdc("status", `USX_A_STATUS, 32'h20);
    rdc("ctrlB", `USX_A_CTRLB, 32'h0);
    rdc("ctrlC", `USX_A_CTRLC, 32'h6);
    rdc("baud", `USX_A_BAUD, 32'h0);
    rdc("unmapped", 12'h014, 32'h0);
    chk("slvErr", 32'h1, rerr);
    wr(`USX_A_BAUD, 32'h3);
    chk("slvErrWr", 32'h0, rerr);
    wr(`USX_A_CTRLC, 32'h26);
    wr(`USX_A_CTRLB, 32'h78);
    chk("udreIrq", 32'h1, udreIrq);
    chk("rxOvr", 32'h1, sInOvr);
    // Second write lands while the first frame shifts, so the buffer stays full
    wr(`USX_A_DATA, 32'hA5);
    wr(`USX_A_DATA, 32'h07);
    rdc("status", `USX_A_STATUS, 32'h0);
    chk("udreIrq", 32'h0, udreIrq);
    chkTx(10'h2A5);
    chkTx(10'h307);
    waitSt(32'h40);
    chk("txcIrq", 32'h1, txcIrq);
    gie <= 1'h0;
    @(posedge core_clk);
    chk("txcIrq", 32'h0, txcIrq);
    gie <= 1'h1;
    rdc("status", `USX_A_STATUS, 32'h60);
    wr(`USX_A_STATUS, 32'h40);
    rdc("status", `USX_A_STATUS, 32'h20);
    wr(`USX_A_CTRLB, 32'h58);
    chk("udreIrq", 32'h0, udreIrq);
    // Odd parity; transmitter switched off while the frame is still pending
    wr(`USX_A_CTRLC, 32'h36);
    wr(`USX_A_DATA, 32'h0E);
    wr(`USX_A_CTRLB, 32'hD0);
    chk("txOe", 32'h1, sOutEn);
    chkTx(10'h20E);
    waitSt(32'h40);
    ack <= 1'h1;
    @(posedge core_clk);
    ack <= 1'h0;
    @(posedge core_clk);
    rdc("status", `USX_A_STATUS, 32'h20);
    chk("txOe", 32'h0, sOutEn);
    // Reception, errors, FIFO depth and overrun
    node.send(fr(9'h5A, 8, 1'h1, 1'h1, 1'h1));
    chk("rxcIrq", 32'h1, rxcIrq);
    rdc("status", `USX_A_STATUS, 32'hA0);
    rdc("data", `USX_A_DATA, 32'h5A);
    chk("rxcIrq", 32'h0, rxcIrq);
    rdc("empty", `USX_A_DATA, 32'h0);
    node.send(fr(9'h01, 8, 1'h1, 1'h1, 1'h0));
    node.send(fr(9'h02, 8, 1'h1, 1'h0, 1'h1));
    node.send(fr(9'h03, 8, 1'h1, 1'h1, 1'h1));
    rdc("status", `USX_A_STATUS, 32'hB0);
    rdc("data", `USX_A_DATA, 32'h01);
    rdc("status", `USX_A_STATUS, 32'hA4);
    rdc("data", `USX_A_DATA, 32'h02);
    rdc("status", `USX_A_STATUS, 32'h20);
    node.send(fr(9'h04, 8, 1'h1, 1'h1, 1'h1));
    rdc("status", `USX_A_STATUS, 32'hA8);
    rdc("data", `USX_A_DATA, 32'h04);
    node.send(fr(9'h05, 8, 1'h1, 1'h1, 1'h1));
    wr(`USX_A_CTRLB, 32'hC0);
    chk("rxOvr", 32'h0, sInOvr);
    rdc("status", `USX_A_STATUS, 32'h20);
    // Nine-bit characters both ways, ninth bit written first
    wr(`USX_A_CTRLC, 32'h06);
    wr(`USX_A_CTRLB, 32'h1D);
    wr(`USX_A_DATA, 32'h96);
    chkTx(10'h396);
    node.send(fr(9'h1C3, 9, 1'h0, 1'h0, 1'h1));
    rdc("status", `USX_A_STATUS, 32'hE0);
    rdc("ctrlB", `USX_A_CTRLB, 32'h1F);
    rdc("data", `USX_A_DATA, 32'hC3);
    // Five-bit character; idle ones after the stop must not leak into the data
    wr(`USX_A_CTRLB, 32'h10);
    wr(`USX_A_CTRLC, 32'h00);
    node.send(fr(9'h15, 5, 1'h0, 1'h0, 1'h1));
    rdc("data", `USX_A_DATA, 32'h15);
    // Synchronous mode; a fast internal divider would garble the bits if it were used instead
    wr(`USX_A_BAUD, 32'h0);
    wr(`USX_A_CTRLC, 32'h40);
    node.send(fr(9'h0B, 5, 1'h0, 1'h0, 1'h1));
    rdc("syncData", `USX_A_DATA, 32'h0B);
    endOfTest();
  end
endmodule : tb
`default_nettype wire
